// ---- debugger_control_status.sv ----
// debugger control and status registers with break and counter logic
`timescale 1ns/1ps
module debugger_control_status #(
   parameter int COUNT_W = 16
) (
   input  wire logic               clk,
   input  wire logic               rst_n,
   // host command port
   input  wire logic               cmd_valid,
   input  wire logic [7:0]         cmd_code,
   input  wire logic [7:0]         cmd_data,
   output logic                    rd_valid,
   output logic [7:0]              rd_data,
   // acknowledge byte towards the host link
   output logic                    ack_valid,
   output logic [7:0]              ack_data,
   // processor core
   input  wire logic               opcode_decode,
   input  wire logic [7:0]         opcode,
   input  wire logic [COUNT_W-1:0] prog_counter,
   input  wire logic               core_halt_state,
   output logic                    fetch_stop,
   output logic                    break_loop,
   output logic                    device_reset,
   // counter load from the counter write command
   input  wire logic               count_load,
   input  wire logic [COUNT_W-1:0] count_value,
   output logic [COUNT_W-1:0]      debug_counter,
   // read-protect option pin, programmed 0 means enabled
   input  wire logic               read_protect_n
);
   logic lock_sync;
   logic [7:0]         ctl_r, ctl_nxt;
   logic               brk_seen_r, brk_seen_nxt;
   logic [COUNT_W-1:0] cnt_r, cnt_nxt, cnt_base_r, cnt_base_nxt;
   logic [7:0]         rst_cnt_r, rst_cnt_nxt;
   logic               rd_valid_r, rd_valid_nxt;
   logic [7:0]         rd_data_r, rd_data_nxt;
   logic               ack_valid_r, ack_valid_nxt;
   logic               dev_rst_r, dev_rst_nxt;
   logic               halt_st_r, lock_st_r;
   logic               brk_loop_r, brk_loop_nxt;
   logic               brk_hit, brk_halt, pc_hit, zero_hit, ctl_wr;
   logic [7:0]         wr_val, status;

   // option pin comes from outside the clock domain
   sync3 i_sync3 (
      .clk   (clk),
      .rst_n (rst_n),
      .din   (~read_protect_n),
      .dout  (lock_sync)
   );

   // break source decode
   always_comb begin
      ctl_wr   = cmd_valid && (cmd_code == debug_unit_pkg::CMD_CTL_WRITE);
      brk_hit  = opcode_decode && (opcode == debug_unit_pkg::BREAK_OPCODE)
                 && ctl_r[debug_unit_pkg::CTL_BREAK_OPCODE_ENABLE_BIT];
      brk_halt = brk_hit && !ctl_r[debug_unit_pkg::CTL_SPIN_BIT];
      pc_hit   = ctl_r[debug_unit_pkg::CTL_PCM_BIT]
                 && !ctl_r[debug_unit_pkg::CTL_HALT_BIT]
                 && (prog_counter == cnt_r);
      zero_hit = ctl_r[debug_unit_pkg::CTL_ZERO_BIT]
                 && !ctl_r[debug_unit_pkg::CTL_PCM_BIT]
                 && !ctl_r[debug_unit_pkg::CTL_HALT_BIT]
                 && (cnt_r == COUNT_W'(1));
      // reserved bit forced to zero whatever the host sends
      wr_val   = cmd_data & ~(8'h01 << debug_unit_pkg::CTL_RSV_BIT);
   end

   // control register next value
   always_comb begin
      ctl_nxt = ctl_r;
      if (ctl_wr) begin
         ctl_nxt = wr_val;
         if (lock_sync && ctl_r[debug_unit_pkg::CTL_HALT_BIT]) begin
            ctl_nxt[debug_unit_pkg::CTL_HALT_BIT] = 1'b1;
         end
         // a pending reset request is not withdrawn by a new write
         if (ctl_r[debug_unit_pkg::CTL_RST_BIT]) begin
            ctl_nxt[debug_unit_pkg::CTL_RST_BIT] = 1'b1;
         end
      end
      if (dev_rst_r && (rst_cnt_r == 8'h01)) begin
         ctl_nxt[debug_unit_pkg::CTL_RST_BIT] = 1'b0;
      end
      // hardware break sets win over a same-cycle clear
      if (brk_halt || pc_hit || zero_hit) begin
         ctl_nxt[debug_unit_pkg::CTL_HALT_BIT] = 1'b1;
      end
      // core loops on break only while both enable and spin are set
      brk_loop_nxt = ctl_nxt[debug_unit_pkg::CTL_BREAK_OPCODE_ENABLE_BIT]
                     && ctl_nxt[debug_unit_pkg::CTL_SPIN_BIT];
   end

   // break record, counter and reset sequencer next values
   always_comb begin
      brk_seen_nxt = brk_seen_r;
      if (ctl_wr) begin
         brk_seen_nxt = 1'b0;
      end
      if (brk_hit) begin
         brk_seen_nxt = 1'b1;
      end
      cnt_base_nxt = cnt_base_r;
      cnt_nxt      = cnt_r;
      if (count_load && ctl_r[debug_unit_pkg::CTL_HALT_BIT]) begin
         cnt_nxt      = count_value;
         cnt_base_nxt = count_value;
      end else if (ctl_r[debug_unit_pkg::CTL_HALT_BIT]
                   && !ctl_nxt[debug_unit_pkg::CTL_HALT_BIT]
                   && !ctl_r[debug_unit_pkg::CTL_ZERO_BIT]) begin
         cnt_nxt = cnt_base_r;
      end else if (!ctl_r[debug_unit_pkg::CTL_HALT_BIT]
                   && !ctl_r[debug_unit_pkg::CTL_PCM_BIT]
                   && (cnt_r != debug_unit_pkg::COUNT_ZERO)) begin
         cnt_nxt = cnt_r - COUNT_W'(1);
      end
      rst_cnt_nxt = rst_cnt_r;
      dev_rst_nxt = dev_rst_r;
      if (dev_rst_r) begin
         rst_cnt_nxt = rst_cnt_r - 8'h01;
         if (rst_cnt_r == 8'h01) begin
            dev_rst_nxt = 1'b0;
         end
      end else if (ctl_wr && wr_val[debug_unit_pkg::CTL_RST_BIT]) begin
         dev_rst_nxt = 1'b1;
         rst_cnt_nxt = 8'(debug_unit_pkg::RESET_CYCLES);
      end
   end

   // status assembly and host read / acknowledge
   always_comb begin
      status = 8'h00;
      status[debug_unit_pkg::STAT_IDLE_BIT] =
         ctl_r[debug_unit_pkg::CTL_HALT_BIT] || brk_seen_r;
      status[debug_unit_pkg::STAT_HALT_BIT] = halt_st_r;
      status[debug_unit_pkg::STAT_LOCK_BIT] = lock_st_r;
      rd_valid_nxt = 1'b0;
      rd_data_nxt  = rd_data_r;
      if (cmd_valid && (cmd_code == debug_unit_pkg::CMD_CTL_READ)) begin
         rd_valid_nxt = 1'b1;
         rd_data_nxt  = ctl_r;
      end else if (cmd_valid
                   && (cmd_code == debug_unit_pkg::CMD_STATUS_READ)) begin
         rd_valid_nxt = 1'b1;
         rd_data_nxt  = status;
      end
      ack_valid_nxt = ctl_r[debug_unit_pkg::CTL_ACK_BIT]
                      && (brk_halt || pc_hit || zero_hit);
   end

   // state registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl_r       <= debug_unit_pkg::CTL_RESET;
         brk_seen_r  <= 1'b0;
         cnt_r       <= COUNT_W'(debug_unit_pkg::COUNT_RESET);
         cnt_base_r  <= COUNT_W'(debug_unit_pkg::COUNT_RESET);
         rst_cnt_r   <= 8'h00;
         dev_rst_r   <= 1'b0;
         rd_valid_r  <= 1'b0;
         rd_data_r   <= 8'h00;
         ack_valid_r <= 1'b0;
         halt_st_r   <= 1'b0;
         lock_st_r   <= 1'b0;
         brk_loop_r  <= 1'b0;
      end else begin
         ctl_r       <= ctl_nxt;
         brk_seen_r  <= brk_seen_nxt;
         cnt_r       <= cnt_nxt;
         cnt_base_r  <= cnt_base_nxt;
         rst_cnt_r   <= rst_cnt_nxt;
         dev_rst_r   <= dev_rst_nxt;
         rd_valid_r  <= rd_valid_nxt;
         rd_data_r   <= rd_data_nxt;
         ack_valid_r <= ack_valid_nxt;
         halt_st_r   <= core_halt_state;
         lock_st_r   <= lock_sync;
         brk_loop_r  <= brk_loop_nxt;
      end
   end

   // outputs straight from flip-flops, except ack_data which is the constant ACK_BYTE
   assign fetch_stop    = ctl_r[debug_unit_pkg::CTL_HALT_BIT];
   assign break_loop    = brk_loop_r;
   assign device_reset  = dev_rst_r;
   assign rd_valid      = rd_valid_r;
   assign rd_data       = rd_data_r;
   assign ack_valid     = ack_valid_r;
   assign ack_data      = debug_unit_pkg::ACK_BYTE;
   assign debug_counter = cnt_r;

   // halt sources, break record and acknowledge
   a_halt_on_brk: assert property (
      @(posedge clk) disable iff (!rst_n)
      brk_halt |=> ctl_r[7])
      else $error("break did not set halt");
   a_lock_holds: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctl_wr && lock_sync && ctl_r[7] && !cmd_data[7]) |=> ctl_r[7])
      else $error("halt cleared under read lock");
   a_nop_disabled: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!ctl_r[6] && !pc_hit && !zero_hit && !ctl_wr && !ctl_r[7])
      |=> !ctl_r[7])
      else $error("halt set with break disabled");
   a_spin_no_halt: assert property (
      @(posedge clk) disable iff (!rst_n)
      (brk_hit && ctl_r[4] && !pc_hit && !zero_hit && !ctl_wr && !ctl_r[7])
      |=> !ctl_r[7])
      else $error("spin break entered debug mode");
   a_loop_out: assert property (
      @(posedge clk) disable iff (!rst_n)
      break_loop == (ctl_r[6] && ctl_r[4]))
      else $error("break loop output wrong");
   a_brk_seen: assert property (
      @(posedge clk) disable iff (!rst_n)
      brk_hit |=> brk_seen_r)
      else $error("break not recorded");
   a_idle_clear: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctl_wr && !brk_hit) |=> !brk_seen_r)
      else $error("break record survived write");
   a_ack_sent: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctl_r[5] && brk_halt) |=> ack_valid)
      else $error("ack byte missing");
   a_ack_only: assert property (
      @(posedge clk) disable iff (!rst_n)
      !(brk_halt || pc_hit || zero_hit) |=> !ack_valid)
      else $error("ack byte without breakpoint");
   a_pc_break: assert property (
      @(posedge clk) disable iff (!rst_n)
      pc_hit |=> fetch_stop)
      else $error("pc match did not halt");

   // debug counter
   a_count_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctl_r[3] && !ctl_r[7] && !count_load) |=> $stable(cnt_r))
      else $error("counter moved under pc match");
   a_count_down: assert property (
      @(posedge clk) disable iff (!rst_n)
      (!ctl_r[7] && !ctl_r[3] && (cnt_r != COUNT_W'(0)))
      |=> (cnt_r == ($past(cnt_r) - COUNT_W'(1))))
      else $error("counter did not step down");
   a_zero_break: assert property (
      @(posedge clk) disable iff (!rst_n)
      zero_hit |=> (fetch_stop && (cnt_r == COUNT_W'(0))))
      else $error("zero count did not halt");
   a_reload_hold: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctl_r[7] && !ctl_nxt[7] && ctl_r[2] && !count_load)
      |=> $stable(cnt_r))
      else $error("counter reloaded under zero break");

   // control writes, reset request and host reads
   a_ctl_write: assert property (
      @(posedge clk) disable iff (!rst_n)
      (ctl_wr && !lock_sync && !ctl_r[0] && !dev_rst_r
       && !brk_halt && !pc_hit && !zero_hit)
      |=> (ctl_r == ($past(cmd_data) & 8'hFD)))
      else $error("control write not stored");
   a_reset_pulse: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(dev_rst_r) |-> ##9 dev_rst_r ##1 !dev_rst_r)
      else $error("device reset pulse length wrong");
   a_reset_ends: assert property (
      @(posedge clk) disable iff (!rst_n)
      $rose(dev_rst_r) |-> ##[1:20] !ctl_r[0])
      else $error("reset request did not clear");
   a_rd_answer: assert property (
      @(posedge clk) disable iff (!rst_n)
      (cmd_valid && (cmd_code == 8'h05))
      |=> (rd_valid && (rd_data == $past(ctl_r))))
      else $error("control read answer wrong");
   a_status_rsv: assert property (
      @(posedge clk) disable iff (!rst_n)
      (rd_valid && ($past(cmd_code) == 8'h02)) |-> (rd_data[4:0] == 5'h00))
      else $error("reserved status bits not zero");
   a_lock_status: assert property (
      @(posedge clk) disable iff (!rst_n)
      lock_st_r == $past(lock_sync))
      else $error("read lock status lags");
endmodule : debugger_control_status

// ---- debug_unit_pkg.sv ----
// constants shared by the debugger control and status logic
package debug_unit_pkg;
   // host command codes
   localparam logic [7:0] CMD_STATUS_READ = 8'h02;
   localparam logic [7:0] CMD_CTL_WRITE   = 8'h04;
   localparam logic [7:0] CMD_CTL_READ    = 8'h05;
   // control field positions
   localparam int CTL_HALT_BIT   = 7;
   localparam int CTL_BREAK_OPCODE_ENABLE_BIT  = 6;
   localparam int CTL_ACK_BIT    = 5;
   localparam int CTL_SPIN_BIT   = 4;
   localparam int CTL_PCM_BIT    = 3;
   localparam int CTL_ZERO_BIT   = 2;
   localparam int CTL_RSV_BIT    = 1;
   localparam int CTL_RST_BIT    = 0;
   // status field positions
   localparam int STAT_IDLE_BIT  = 7;
   localparam int STAT_HALT_BIT  = 6;
   localparam int STAT_LOCK_BIT  = 5;
   // reset values, zero count, acknowledge byte and break opcode
   localparam logic [7:0]  CTL_RESET     = 8'h00;
   localparam logic [15:0] COUNT_RESET   = 16'h0000;
   localparam logic [15:0] COUNT_ZERO    = 16'h0000;
   localparam logic [7:0]  ACK_BYTE      = 8'hFF;
   localparam logic [7:0]  BREAK_OPCODE  = 8'h00;
   // length of the device reset pulse in system clocks
   localparam int RESET_TIME_NS  = 100;
   localparam int CLK_PERIOD_NS  = 10;
   localparam int RESET_CYCLES   =
      (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : debug_unit_pkg

// ---- sync3.sv ----
// three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ps
module sync3 (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      dout
);
   logic s1_r, s2_r, s3_r, out_r;
   logic out_nxt;

   // change counts only when stages two and three agree
   always_comb begin
      out_nxt = (s2_r == s3_r) ? s2_r : out_r;
   end

   // register chain
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r  <= 1'b0;
         s2_r  <= 1'b0;
         s3_r  <= 1'b0;
         out_r <= 1'b0;
      end else begin
         s1_r  <= din;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         out_r <= out_nxt;
      end
   end

   assign dout = out_r;
endmodule : sync3

// ---- debug_host.sv ----
// host model that issues debugger commands on the falling edge
`timescale 1ns/1ps
module debug_host (
   input  wire logic       clk,
   input  wire logic       rd_valid,
   input  wire logic [7:0] rd_data,
   output logic            cmd_valid,
   output logic [7:0]      cmd_code,
   output logic [7:0]      cmd_data
);
   logic [7:0] rd_byte;
   // idle command port from time zero
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 8'h00;
      cmd_data  = 8'h00;
   end
   // one command with its data byte, held for one taking edge
   task automatic issue(input logic [7:0] code, input logic [7:0] data);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd_code  = code;
      cmd_data  = data & 8'hFD;
      @(negedge clk);
      cmd_valid = 1'b0;
   endtask : issue
   // control write
   task automatic wr(input logic [7:0] data);
      issue(debug_unit_pkg::CMD_CTL_WRITE, data);
   endtask : wr
   // read with a bounded wait, unknown byte when no answer came
   task automatic rd(input logic [7:0] code);
      rd_byte = 8'hXX;
      issue(code, 8'h00);
      for (int i = 0; i < 4; i++) begin
         if (rd_valid === 1'b1) begin
            rd_byte = rd_data;
            break;
         end
         @(negedge clk);
      end
   endtask : rd
endmodule : debug_host

// ---- debugger_control_status_tb.sv ----
// self-checking testbench for the debugger control and status block
`timescale 1ns/1ps
module debugger_control_status_tb;
   logic        clk, rst_n, cmd_valid, rd_valid, ack_valid;
   logic        opcode_decode, core_halt_state, fetch_stop;
   logic        break_loop, device_reset, count_load, read_protect_n;
   logic [7:0]  cmd_code, cmd_data, rd_data, ack_data, opcode;
   logic [15:0] prog_counter, count_value, debug_counter;
   int          failures;
   int          samples_checked;

   debugger_control_status i_debugger_control_status (
      .clk             (clk),
      .rst_n           (rst_n),
      .cmd_valid       (cmd_valid),
      .cmd_code        (cmd_code),
      .cmd_data        (cmd_data),
      .rd_valid        (rd_valid),
      .rd_data         (rd_data),
      .ack_valid       (ack_valid),
      .ack_data        (ack_data),
      .opcode_decode   (opcode_decode),
      .opcode          (opcode),
      .prog_counter    (prog_counter),
      .core_halt_state (core_halt_state),
      .fetch_stop      (fetch_stop),
      .break_loop      (break_loop),
      .device_reset    (device_reset),
      .count_load      (count_load),
      .count_value     (count_value),
      .debug_counter   (debug_counter),
      .read_protect_n  (read_protect_n)
   );
   debug_host i_debug_host (
      .clk       (clk),
      .rd_valid  (rd_valid),
      .rd_data   (rd_data),
      .cmd_valid (cmd_valid),
      .cmd_code  (cmd_code),
      .cmd_data  (cmd_data)
   );

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // compare and count
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask : tick
   task automatic rctl(input logic [7:0] exp);
      i_debug_host.rd(debug_unit_pkg::CMD_CTL_READ);
      chk(i_debug_host.rd_byte, exp);
   endtask : rctl
   task automatic rst(input logic [7:0] exp);
      i_debug_host.rd(debug_unit_pkg::CMD_STATUS_READ);
      chk(i_debug_host.rd_byte, exp);
   endtask : rst
   // one decoded opcode for a single cycle, 00H being the break opcode
   task automatic break_opcode(input logic [7:0] op);
      @(negedge clk);
      opcode_decode = 1'b1;
      opcode        = op;
      @(negedge clk);
      opcode_decode = 1'b0;
      opcode        = ~op;
   endtask : break_opcode
   task automatic do_reset;
      rst_n = 1'b0;
      tick(3);
      rst_n = 1'b1;
   endtask : do_reset
   // counts device reset cycles, bounded
   task automatic pulse_len(output int n);
      n = 0;
      for (int i = 0; i < 20; i++) begin
         if (device_reset === 1'b1) n++;
         @(negedge clk);
      end
   endtask : pulse_len
   task automatic load(input logic [15:0] v);
      @(negedge clk);
      count_load  = 1'b1;
      count_value = v;
      @(negedge clk);
      count_load  = 1'b0;
   endtask : load
   // reset values and disabled break opcode
   task automatic t_idle;
      rctl(8'h00);
      rst(8'h00);
      break_opcode(debug_unit_pkg::BREAK_OPCODE);
      tick(1);
      chk(fetch_stop, 1'b0);
      rst(8'h00);
      i_debug_host.wr(8'h40);
      break_opcode(8'h01);
      chk(fetch_stop, 1'b0);
      rst(8'h00);
      i_debug_host.issue(8'h03, 8'hFF);
      rctl(8'h40);
      i_debug_host.wr(8'h00);
   endtask : t_idle
   // break enters debug mode with acknowledge, then resume
   task automatic t_break;
      i_debug_host.wr(8'h60);
      break_opcode(debug_unit_pkg::BREAK_OPCODE);
      chk({ack_valid, ack_data}, 9'h1FF);
      chk(fetch_stop, 1'b1);
      rst(8'h80);
      i_debug_host.wr(8'h00);
      chk(fetch_stop, 1'b0);
      rst(8'h00);
   endtask : t_break
   // spin select loops on break without debug mode
   task automatic t_spin;
      i_debug_host.wr(8'h50);
      chk(break_loop, 1'b1);
      break_opcode(debug_unit_pkg::BREAK_OPCODE);
      chk({fetch_stop, ack_valid}, 2'b00);
      rst(8'h80);
      i_debug_host.wr(8'h00);
   endtask : t_spin
   // reset-and-stop, run, reset-and-go
   task automatic t_resets;
      int n;
      i_debug_host.wr(8'h81);
      pulse_len(n);
      chk(n, debug_unit_pkg::RESET_CYCLES);
      chk(fetch_stop, 1'b1);
      rctl(8'h80);
      i_debug_host.wr(8'h40);
      chk(fetch_stop, 1'b0);
      i_debug_host.wr(8'h41);
      pulse_len(n);
      chk(n, debug_unit_pkg::RESET_CYCLES);
      rctl(8'h40);
      i_debug_host.wr(8'h00);
   endtask : t_resets
   // read lock keeps halt, halt status follows core
   task automatic t_lock;
      read_protect_n = 1'b0;
      core_halt_state = 1'b1;
      tick(6);
      rst(8'h60);
      core_halt_state = 1'b0;
      i_debug_host.wr(8'h80);
      i_debug_host.wr(8'h00);
      rctl(8'h80);
      read_protect_n = 1'b1;
      do_reset;
      chk(fetch_stop, 1'b0);
   endtask : t_lock
   // zero count break and pc match break
   task automatic t_count;
      i_debug_host.wr(8'h80);
      load(16'h0005);
      chk(debug_counter, 16'h0005);
      i_debug_host.wr(8'h04);
      for (int i = 0; i < 20 && fetch_stop !== 1'b1; i++) tick(1);
      chk(fetch_stop, 1'b1);
      chk(debug_counter, 16'h0000);
      // leaving debug with zero break on keeps the count
      i_debug_host.wr(8'h04);
      tick(2);
      chk(debug_counter, 16'h0000);
      // leaving debug with zero break off reloads the count
      i_debug_host.wr(8'h80);
      i_debug_host.wr(8'h00);
      chk(debug_counter, 16'h0005);
      i_debug_host.wr(8'h80);
      load(16'h0123);
      i_debug_host.wr(8'h28);
      for (int i = 0; i < 5; i++) begin
         prog_counter = 16'h0118 + 16'(i);
         tick(1);
      end
      chk(fetch_stop, 1'b0);
      chk(debug_counter, 16'h0123);
      prog_counter = 16'h0123;
      tick(1);
      chk(ack_valid, 1'b1);
      chk(fetch_stop, 1'b1);
   endtask : t_count
   task automatic wrap_up;
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : wrap_up
   // main sequence
   initial begin
      failures = 0;
      samples_checked = 0;
      rst_n = 1'b0;
      {opcode_decode, core_halt_state, count_load} = 3'b000;
      read_protect_n = 1'b1;
      opcode = 8'hA5;
      prog_counter = 16'h0000;
      count_value = 16'h0000;
      do_reset;
      t_idle;
      t_break;
      t_spin;
      t_resets;
      t_lock;
      t_count;
      wrap_up;
   end
endmodule : debugger_control_status_tb
